/* rtl/meter_fieldbus_slave_cfg.svh */
// Constants of the meter fieldbus slave: codes, offsets, timing counts
`ifndef METER_FIELDBUS_SLAVE_CFG_SVH
`define METER_FIELDBUS_SLAVE_CFG_SVH

// Function codes served on the request link
`define MFS_FC_READ_HOLD    8'h03
`define MFS_FC_WRITE_COIL   8'h05
`define MFS_FC_WRITE_MULTI  8'h10
`define MFS_FC_REPORT_ID    8'h11

// Value register addresses on the M-Bus read port
`define MFS_MBUS_TOTAL      2'h1
`define MFS_MBUS_FLOW       2'h2
`define MFS_MBUS_STATUS     2'h3

// Frame sizes and positions in bytes, and the read quantity limit in registers
`define MFS_LEN_FIXED       8'h08
`define MFS_LEN_MULTI_HDR   8'h09
`define MFS_LEN_REPORT_REQ  8'h04
`define MFS_LEN_MIN         8'h04
`define MFS_ECHO_LEN        8'h06
`define MFS_ID_BYTE_COUNT   8'h1a
`define MFS_ID_LEN          8'h1d
`define MFS_NAME_FIRST      8'h09
`define MFS_MAX_READ_QTY    8'h7d

// Identity fields; the values are arbitrary
`define MFS_SLAVE_ID        16'h0001
`define MFS_RUN_INDICATOR   16'h00ff
`define MFS_PRODUCT_CODE    16'h0a5c
`define MFS_PRODUCT_NAME    "FLOW METER SLAVE    "

// Coil values
`define MFS_COIL_ON         16'hff00
`define MFS_COIL_OFF        16'h0000

// CRC-16 seed and reflected polynomial
`define MFS_CRC_SEED        16'hffff
`define MFS_CRC_POLY        16'ha001

// Inter-frame gap: 7 characters of 10 bits at 19200 baud, 20 MHz clock
`define MFS_CLK_HZ          20000000
`define MFS_BAUD            19200
`define MFS_CHAR_BITS       10
`define MFS_GAP_CHARS       7
`define MFS_GAP_CYC ((`MFS_GAP_CHARS * `MFS_CHAR_BITS * `MFS_CLK_HZ \
                      + `MFS_BAUD - 1) / `MFS_BAUD)

`endif

/* rtl/meter_fieldbus_slave_pkg.sv */
// Types of the meter fieldbus slave
package meter_fieldbus_slave_pkg;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_CHECK = 5'b00010,
      ST_BODY  = 5'b00100,
      ST_CRCL  = 5'b01000,
      ST_CRCH  = 5'b10000
   } slave_state_t;
   typedef logic [7:0] byte_t;
endpackage

/* rtl/mfs_crc16.sv */
// Byte-wide frame check engine, one byte per cycle
`timescale 1ns/1ps
`include "meter_fieldbus_slave_cfg.svh"
module mfs_crc16 (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        clear,
   input  wire logic        enable,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc_q
);
   // Eight shift steps of the reflected polynomial folded into one cycle
   function automatic logic [15:0] next_crc(input logic [15:0] c,
                                            input logic [7:0]  d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `MFS_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Clear wins so a new frame never inherits an old remainder
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_q <= `MFS_CRC_SEED;
      end else if (clear) begin
         crc_q <= `MFS_CRC_SEED;
      end else if (enable) begin
         crc_q <= next_crc(crc_q, data);
      end
   end
endmodule

/* rtl/meter_fieldbus_slave.sv */
// Fieldbus slave of a flow meter: request parser and reply builder
// Function
// - Read holding registers replies address, function, byte count, words.
// - Write single coil replies by echoing the six request fields.
// - Write multiple registers replies with address, function, start, qty.
// - Report identity replies with count, id, run, code and 20-byte name.
// - The M-Bus port serves total, flow and status at addresses 1, 2, 3.
// - Each 32-bit value goes out as low word then high word, high byte first.
// - Frames are delimited by an idle gap of seven character times.
`timescale 1ns/1ps
`include "meter_fieldbus_slave_cfg.svh"
module meter_fieldbus_slave
   import meter_fieldbus_slave_pkg::*;
#(
   parameter int GAP_CYCLES = `MFS_GAP_CYC
) (
   input  wire logic                           sys_clk,
   input  wire logic                           rst_b,
   input  wire logic [7:0]                     slave_addr,
   input  wire logic                           rx_valid,
   input  wire meter_fieldbus_slave_pkg::byte_t rx_data,
   output logic                                tx_valid_q,
   output meter_fieldbus_slave_pkg::byte_t     tx_byte_q,
   input  wire logic                           tx_ready,
   output logic                                coil_q,
   input  wire logic [31:0]                    total_consumption_value,
   input  wire logic [31:0]                    flow_value,
   input  wire logic [31:0]                    bus_status_word,
   input  wire logic [1:0]                     mbus_addr,
   output logic      [31:0]                    mbus_data_q
);
   import meter_fieldbus_slave_pkg::*;

   localparam logic [16:0] GAP_LAST = 17'(GAP_CYCLES - 1);
   localparam logic [159:0] NAME = `MFS_PRODUCT_NAME;

   slave_state_t st_q;
   byte_t        buf_q [8];
   logic [7:0]   rx_cnt_q;
   logic [16:0]  gap_cnt_q;
   logic [7:0]   tx_idx_q;
   logic [15:0]  rx_crc;
   logic [15:0]  tx_crc;
   logic         rx_take;
   logic         rx_clear;
   logic         tx_take;
   logic         frame_end;
   logic         frame_ok;
   logic [7:0]   body_len;
   byte_t        body_byte;
   byte_t        next_byte;
   logic [15:0]  start_addr;
   logic [15:0]  qty;

   assign rx_take    = (st_q == ST_IDLE) && rx_valid;
   assign rx_clear   = (st_q == ST_CHECK);
   assign tx_take    = (st_q == ST_BODY) && tx_valid_q && tx_ready;
   assign start_addr = {buf_q[2], buf_q[3]};
   assign qty        = {buf_q[4], buf_q[5]};
   // End of frame once the line has been quiet for the full gap
   assign frame_end  = (st_q == ST_IDLE) && (rx_cnt_q != 8'h00) &&
                       !rx_valid && (gap_cnt_q == GAP_LAST);

   mfs_crc16 u_rx_crc (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clear   (rx_clear),
      .enable  (rx_take),
      .data    (rx_data),
      .crc_q   (rx_crc)
   );

   mfs_crc16 u_tx_crc (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clear   (rx_clear),
      .enable  (tx_take),
      .data    (tx_byte_q),
      .crc_q   (tx_crc)
   );

   // Holding word r: pairs 0/1, 2/3, 4/5 hold the three values, low word first
   function automatic logic [15:0] hold_word(input logic [15:0] r);
      unique case (r)
         16'h0000: hold_word = total_consumption_value[15:0];
         16'h0001: hold_word = total_consumption_value[31:16];
         16'h0002: hold_word = flow_value[15:0];
         16'h0003: hold_word = flow_value[31:16];
         16'h0004: hold_word = bus_status_word[15:0];
         16'h0005: hold_word = bus_status_word[31:16];
         default:  hold_word = 16'h0000;
      endcase
   endfunction

   // Request validation: a residue of zero over data plus check means intact
   always_comb begin
      frame_ok = (rx_cnt_q >= `MFS_LEN_MIN) && (rx_crc == 16'h0000) &&
                 (buf_q[0] == slave_addr) && (slave_addr != 8'h00);
      unique case (buf_q[1])
         `MFS_FC_READ_HOLD:
            frame_ok = frame_ok && (rx_cnt_q == `MFS_LEN_FIXED) &&
                       (buf_q[4] == 8'h00) && (buf_q[5] != 8'h00) &&
                       (buf_q[5] <= `MFS_MAX_READ_QTY);
         `MFS_FC_WRITE_COIL:
            frame_ok = frame_ok && (rx_cnt_q == `MFS_LEN_FIXED);
         `MFS_FC_WRITE_MULTI:
            frame_ok = frame_ok && (buf_q[4] == 8'h00) &&
                       (buf_q[6] == 8'(buf_q[5] << 1)) &&
                       (rx_cnt_q == 8'(`MFS_LEN_MULTI_HDR + buf_q[6]));
         `MFS_FC_REPORT_ID:
            frame_ok = frame_ok && (rx_cnt_q == `MFS_LEN_REPORT_REQ);
         default: frame_ok = 1'b0;
      endcase
   end

   // Reply length and the reply byte that follows the one at tx_idx_q;
   // byte 0 is loaded when the request is accepted, so n starts at 1
   always_comb begin
      logic [7:0]  n;
      logic [7:0]  k;
      logic [15:0] w;
      n         = 8'(tx_idx_q + 8'h01);
      k         = 8'(n - 8'h03);
      w         = hold_word(16'(start_addr + {9'h000, k[7:1]}));
      body_len  = `MFS_ECHO_LEN;
      body_byte = buf_q[n[2:0]];
      if (n == 8'h01) begin
         body_byte = buf_q[1];
      end else if (buf_q[1] == `MFS_FC_READ_HOLD) begin
         if (n == 8'h02) begin
            body_byte = 8'(buf_q[5] << 1);
         end else begin
            body_byte = k[0] ? w[7:0] : w[15:8];
         end
      end else if (buf_q[1] == `MFS_FC_REPORT_ID) begin
         unique case (n)
            8'h02: body_byte = `MFS_ID_BYTE_COUNT;
            8'h03: body_byte = 8'(`MFS_SLAVE_ID >> 8);
            8'h04: body_byte = 8'(`MFS_SLAVE_ID);
            8'h05: body_byte = 8'(`MFS_RUN_INDICATOR >> 8);
            8'h06: body_byte = 8'(`MFS_RUN_INDICATOR);
            8'h07: body_byte = 8'(`MFS_PRODUCT_CODE >> 8);
            8'h08: body_byte = 8'(`MFS_PRODUCT_CODE);
            default: body_byte = 8'(NAME >> (8'd152 -
                        8'((n - `MFS_NAME_FIRST) << 3)));
         endcase
      end
      if (buf_q[1] == `MFS_FC_READ_HOLD) begin
         body_len = 8'(8'h03 + (buf_q[5] << 1));
      end else if (buf_q[1] == `MFS_FC_REPORT_ID) begin
         body_len = `MFS_ID_LEN;
      end
   end

   // Byte that follows the one being accepted on the transmit side
   always_comb begin
      logic [7:0] save;
      save      = tx_idx_q;
      next_byte = body_byte;
      if (save == 8'hff) begin
         next_byte = 8'h00;
      end
   end

   // Request capture: only the first eight bytes are kept, the rest are
   // counted and checked, which is all that the served functions need
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt_q <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (rx_clear || st_q == ST_CRCH) begin
         if (rx_clear) begin
            rx_cnt_q <= 8'h00;
         end
      end else if (rx_take) begin
         if (rx_cnt_q < 8'h08) begin
            buf_q[rx_cnt_q[2:0]] <= rx_data;
         end
         if (rx_cnt_q != 8'hff) begin
            rx_cnt_q <= rx_cnt_q + 8'h01;
         end
      end
   end

   // Quiet-line counter restarts on every received byte
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_cnt_q <= 17'h00000;
      end else if (rx_take || st_q != ST_IDLE) begin
         gap_cnt_q <= 17'h00000;
      end else if (gap_cnt_q != GAP_LAST) begin
         gap_cnt_q <= gap_cnt_q + 17'h00001;
      end
   end

   // Reply sequencer; bytes arriving while a reply runs are dropped
   // because the serial line is half duplex
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q       <= ST_IDLE;
         tx_valid_q <= 1'b0;
         tx_byte_q  <= 8'h00;
         tx_idx_q   <= 8'h00;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               tx_idx_q <= 8'h00;
               if (frame_end) begin
                  st_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (frame_ok) begin
                  st_q       <= ST_BODY;
                  tx_valid_q <= 1'b1;
                  tx_byte_q  <= slave_addr;
               end else begin
                  st_q <= ST_IDLE;
               end
            end
            ST_BODY: begin
               if (tx_take) begin
                  tx_idx_q <= tx_idx_q + 8'h01;
                  if (tx_idx_q == 8'(body_len - 8'h01)) begin
                     st_q       <= ST_CRCL;
                     tx_valid_q <= 1'b0;   // One idle cycle lets the CRC settle
                  end else begin
                     tx_byte_q <= next_byte;
                  end
               end
            end
            ST_CRCL: begin
               if (!tx_valid_q) begin
                  tx_valid_q <= 1'b1;
                  tx_byte_q  <= tx_crc[7:0];
               end else if (tx_ready) begin
                  st_q      <= ST_CRCH;
                  tx_byte_q <= tx_crc[15:8];
               end
            end
            ST_CRCH: begin
               if (tx_ready) begin
                  st_q       <= ST_IDLE;
                  tx_valid_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // Coil follows the write-single-coil data at coil address zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         coil_q <= 1'b0;
      end else if (st_q == ST_CHECK && frame_ok &&
                   buf_q[1] == `MFS_FC_WRITE_COIL &&
                   start_addr == 16'h0000) begin
         if (qty == `MFS_COIL_ON) begin
            coil_q <= 1'b1;
         end else if (qty == `MFS_COIL_OFF) begin
            coil_q <= 1'b0;
         end
      end
   end

   // M-Bus value read port, answered one cycle after the address
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mbus_data_q <= 32'h00000000;
      end else begin
         unique case (mbus_addr)
            `MFS_MBUS_TOTAL:  mbus_data_q <= total_consumption_value;
            `MFS_MBUS_FLOW:   mbus_data_q <= flow_value;
            `MFS_MBUS_STATUS: mbus_data_q <= bus_status_word;
            default:          mbus_data_q <= 32'h00000000;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_body_start;
      $rose(tx_valid_q) && st_q == ST_BODY;
   endsequence
   sequence s_last_body;
      tx_take && tx_idx_q == 8'(body_len - 8'h01);
   endsequence

   property p_reply_needs_good_frame;
      s_body_start |-> $past(st_q == ST_CHECK && frame_ok);
   endproperty
   a_reply_needs_good_frame: assert property (p_reply_needs_good_frame)
      else $error("reply started without a valid request");

   property p_crc_low_first;
      s_last_body ##1 (st_q == ST_CRCL) |=>
         tx_valid_q && tx_byte_q == tx_crc[7:0];
   endproperty
   a_crc_low_first: assert property (p_crc_low_first)
      else $error("check low byte not sent first");

   property p_gap_before_check;
      st_q == ST_CHECK |-> $past(gap_cnt_q) == GAP_LAST;
   endproperty
   a_gap_before_check: assert property (p_gap_before_check)
      else $error("frame closed before the idle gap");

   property p_read_count;
      st_q == ST_BODY && tx_valid_q && tx_idx_q == 8'h02 &&
      buf_q[1] == `MFS_FC_READ_HOLD |-> tx_byte_q == 8'(buf_q[5] << 1);
   endproperty
   a_read_count: assert property (p_read_count)
      else $error("read reply byte count wrong");

   property p_word_order;
      st_q == ST_BODY && tx_valid_q && tx_idx_q == 8'h03 &&
      buf_q[1] == `MFS_FC_READ_HOLD && start_addr == 16'h0000 &&
      $stable(total_consumption_value)
      |-> tx_byte_q == total_consumption_value[15:8];
   endproperty
   a_word_order: assert property (p_word_order)
      else $error("first value byte not low word high byte");

   property p_coil_echo;
      st_q == ST_BODY && tx_valid_q && tx_idx_q == 8'h04 &&
      buf_q[1] == `MFS_FC_WRITE_COIL |-> tx_byte_q == buf_q[4];
   endproperty
   a_coil_echo: assert property (p_coil_echo)
      else $error("coil reply does not echo data");

   property p_multi_len;
      (s_last_body and buf_q[1] == `MFS_FC_WRITE_MULTI) |->
         tx_idx_q == 8'h05 ##1 st_q == ST_CRCL;
   endproperty
   a_multi_len: assert property (p_multi_len)
      else $error("write multiple reply length wrong");

   property p_id_count;
      st_q == ST_BODY && tx_valid_q && tx_idx_q == 8'h02 &&
      buf_q[1] == `MFS_FC_REPORT_ID |-> tx_byte_q == `MFS_ID_BYTE_COUNT;
   endproperty
   a_id_count: assert property (p_id_count)
      else $error("identity byte count wrong");

   property p_mbus_flow;
      mbus_addr == `MFS_MBUS_FLOW |=> mbus_data_q == $past(flow_value);
   endproperty
   a_mbus_flow: assert property (p_mbus_flow)
      else $error("M-Bus flow value wrong");
endmodule

/* tb/modbus_master_model.sv */
// Request-link master model: sends framed requests, collects reply bytes
`timescale 1ns/1ps
module modbus_master_model
   import meter_fieldbus_slave_pkg::*;
#(
   parameter int GAP_CYCLES = 20
) (
   input  wire logic                            sys_clk,
   output logic                                 rx_valid,
   output meter_fieldbus_slave_pkg::byte_t      rx_data,
   input  wire logic                            tx_valid_q,
   input  wire meter_fieldbus_slave_pkg::byte_t tx_byte_q,
   output logic                                 tx_ready,
   input  wire logic                            slow
);
   byte_t got[$];

   // Idle request link, reply consumer ready
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b1;
   end

   // Frame check, reflected form, one byte at a time
   function automatic logic [15:0] crc16(input byte_t f[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction

   // Whole frame, back to back; bad_crc spoils the check on purpose
   task automatic send(input byte_t f[$], input logic bad_crc);
      logic [15:0] c;
      c = crc16(f) ^ {15'h0000, bad_crc};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         @(posedge sys_clk);
         rx_valid <= 1'b1;
         rx_data  <= f[i];
      end
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_data  <= ~f[f.size()-1]; // Stale data must not look valid
      repeat (GAP_CYCLES + 4) @(posedge sys_clk);
   endtask

   // Collect every byte taken; a slow master stalls on alternate cycles
   always @(posedge sys_clk) begin
      if (tx_valid_q && tx_ready) begin
         got.push_back(tx_byte_q);
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench of the meter fieldbus slave
`timescale 1ns/1ps
`include "meter_fieldbus_slave_cfg.svh"
module testbench;
   import meter_fieldbus_slave_pkg::*;
   localparam int GAP = 20;
   logic          sys_clk = 1'b0;
   logic          rst_b = 1'b0;
   logic [7:0]    slave_addr = 8'h01;
   logic          rx_valid;
   byte_t         rx_data;
   logic          tx_valid_q;
   byte_t         tx_byte_q;
   logic          tx_ready;
   logic          coil_q;
   logic [31:0]   total_consumption_value = 32'h0a11_42c5;
   logic [31:0]   flow_value = 32'h3c4d_5e6f;
   logic [31:0]   bus_status_word = 32'h8001_7002;
   logic [1:0]    mbus_addr = 2'h0;
   logic [31:0]   mbus_data_q;
   logic          slow = 1'b0;
   logic [159:0]  name_str = `MFS_PRODUCT_NAME;
   int            error_cnt = 0;
   int            cmp_count = 0;
   byte_t         q[$];

   // Clock at 20 MHz
   always #25 sys_clk = ~sys_clk;

   meter_fieldbus_slave #(.GAP_CYCLES(GAP)) u_meter_fieldbus_slave (
      .sys_clk                 (sys_clk),
      .rst_b                   (rst_b),
      .slave_addr              (slave_addr),
      .rx_valid                (rx_valid),
      .rx_data                 (rx_data),
      .tx_valid_q              (tx_valid_q),
      .tx_byte_q               (tx_byte_q),
      .tx_ready                (tx_ready),
      .coil_q                  (coil_q),
      .total_consumption_value (total_consumption_value),
      .flow_value              (flow_value),
      .bus_status_word         (bus_status_word),
      .mbus_addr               (mbus_addr),
      .mbus_data_q             (mbus_data_q)
   );

   modbus_master_model #(.GAP_CYCLES(GAP)) u_master (
      .sys_clk    (sys_clk),
      .rx_valid   (rx_valid),
      .rx_data    (rx_data),
      .tx_valid_q (tx_valid_q),
      .tx_byte_q  (tx_byte_q),
      .tx_ready   (tx_ready),
      .slow       (slow)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Reply must be the body followed by its check, low byte first
   task automatic expect_reply(input byte_t body[$]);
      logic [15:0] c;
      int          n;
      c = u_master.crc16(body);
      body.push_back(c[7:0]);
      body.push_back(c[15:8]);
      n = 0;
      while (u_master.got.size() < body.size() && n < 4000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (GAP + 8) @(posedge sys_clk);
      check(32'(u_master.got.size()), 32'(body.size()));
      foreach (body[i]) begin
         if (i < u_master.got.size()) begin
            check({24'h0, u_master.got[i]}, {24'h0, body[i]});
         end
      end
      u_master.got.delete();
   endtask

   // A refused frame leaves the reply link silent
   task automatic expect_none();
      repeat (GAP + 40) @(posedge sys_clk);
      check(32'(u_master.got.size()), 32'h0);
      u_master.got.delete();
   endtask

   // Holding map: each value low word first
   function automatic logic [15:0] hold_word(input int k);
      case (k)
         0: return total_consumption_value[15:0];
         1: return total_consumption_value[31:16];
         2: return flow_value[15:0];
         3: return flow_value[31:16];
         4: return bus_status_word[15:0];
         5: return bus_status_word[31:16];
         default: return 16'h0000;
      endcase
   endfunction

   // Read request and its expected reply, words high byte first
   task automatic read_case(input int start, input int qty);
      byte_t       b[$];
      logic [15:0] w;
      q = {8'h01, 8'h03, 8'h00, 8'(start), 8'h00, 8'(qty)};
      u_master.send(q, 1'b0);
      b = {8'h01, `MFS_FC_READ_HOLD, 8'(qty * 2)};
      for (int k = start; k < start + qty; k++) begin
         w = hold_word(k);
         b.push_back(w[15:8]);
         b.push_back(w[7:0]);
      end
      expect_reply(b);
   endtask

   // Hang guard, far beyond the expected run length
   initial begin
      repeat (40000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      #1 check({31'h0, coil_q}, 32'h0);
      for (int a = 0; a < 4; a++) begin
         @(posedge sys_clk);
         mbus_addr <= 2'(a);
         @(posedge sys_clk);
         @(posedge sys_clk);
         #1;
         check(mbus_data_q, a == 1 ? total_consumption_value : a == 2 ?
               flow_value : a == 3 ? bus_status_word : 32'h0);
      end
      read_case(0, 6);
      slow <= 1'b1;
      read_case(4, 3);
      read_case(0, 125);
      slow <= 1'b0;
      q = {8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
      u_master.send(q, 1'b0);
      expect_none();
      q = {8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7e};
      u_master.send(q, 1'b0);
      expect_none();
      // Coil set then cleared: reply echoes the six fields
      q = {8'h01, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00};
      u_master.send(q, 1'b0);
      expect_reply(q);
      check({31'h0, coil_q}, 32'h1);
      q = {8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
      u_master.send(q, 1'b0);
      expect_reply(q);
      check({31'h0, coil_q}, 32'h0);
      q = {8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
      u_master.send(q, 1'b0);
      q = q[0:5];
      expect_reply(q);
      // Byte count that disagrees with the quantity gets no reply
      q = {8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h04, 8'h12, 8'h34};
      u_master.send(q, 1'b0);
      expect_none();
      q = {8'h01, 8'h11};
      u_master.send(q, 1'b0);
      q = {8'h01, 8'h11, 8'(`MFS_ID_BYTE_COUNT), 8'(`MFS_SLAVE_ID >> 8),
           8'(`MFS_SLAVE_ID), 8'(`MFS_RUN_INDICATOR >> 8),
           8'(`MFS_RUN_INDICATOR), 8'(`MFS_PRODUCT_CODE >> 8),
           8'(`MFS_PRODUCT_CODE)};
      for (int i = 0; i < 20; i++) begin
         q.push_back(name_str[159 - 8 * i -: 8]);
      end
      expect_reply(q);
      // Spoiled check, then a frame for another slave
      q = {8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02};
      u_master.send(q, 1'b1);
      expect_none();
      q = {8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02};
      u_master.send(q, 1'b0);
      expect_none();
      report_and_stop();
   end
endmodule
